// *** hw/mod_control.sv ***
// Notes on behaviour
// - Only one modulation mode enabled at once
// - Burst enable reads back 0 or 1
// - Burst emits count cycles, then holds level
// - Trigger source resets and applies to immediate
// - Immediate source repeats bursts at repeat rate
// - External rising edge starts one burst
// - Trigger wait flag while armed for edge
// - Each bus trigger while armed yields one burst; ones during a burst are dropped
// - External or bus ignores repeat rate
// - Gated source overrides trigger source selection
// - Burst completion answers and flags operation complete
// - Busy held until pending burst finishes
// - Trigger source reads back its code
// - Carrier frequency clamped, default one kilohertz
// - Hop frequency clamped, default hundred hertz
// - Internal keying alternates at clamped shift rate
// - External keying ignores shift rate
// - Keying input low carrier, high hop
// - Keying defaults internal, enable reads 0/1
// - Sweep direction from start versus stop
// - Sweep holds duration and spacing select
// - Burst count 1 to 50000, default 1
// - Gate high outputs waveform, low holds level
`timescale 1ns/1ps
`include "modctl_cfg.svh"
module mod_control #(
  parameter int unsigned BPER_DEF = 32'(`CLK_HZ * 64'd1000 / `BRATE_DEF_MHZ),
  parameter int unsigned SPER_DEF = 32'(`CLK_HZ * 64'd1000 / `SRATE_DEF_MHZ)
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst_n,
  input  wire logic [5:0]               i_addr,
  input  wire logic [31:0]              i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  input  wire logic                     i_ext_trig,
  input  wire logic                     i_group_trigger,
  input  wire logic                     i_keying_level_input,
  input  wire logic                     i_cycle_wrap,
  output logic [31:0]                   o_rdata,
  output logic                          o_out_enable,
  output logic                          o_burst_start,
  output logic [31:0]                   o_burst_phase,
  output logic                          o_burst_done,
  output logic                          o_op_complete,
  output logic                          o_busy,
  output logic                          o_trig_wait,
  output logic                          o_sel_hop,
  output logic [31:0]                   o_freq,
  output modctl_pkg::trig_src_t         o_trigger_source_select
);
  import modctl_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // Declarations
  //////////////////////////////////////////////////////////////////////
  localparam logic [31:0] SPER_MIN = 32'(`CLK_HZ * 64'd1000 / `RATE_MAX_MHZ);

  logic [2:0]   mode_q;             // Burst, keying, sweep enables
  trig_src_t    tsrc_q;             // Trigger source select
  logic         bsrc_q;             // Burst source: gated when set
  logic         ksrc_q;             // Keying source: external when set
  logic         space_q;            // Sweep spacing: log when set
  logic         slow_q;             // Triangle or ramp shape limit
  logic [15:0]  bcount_q;           // Burst cycle count
  logic [31:0]  bperiod_q;          // Burst repeat period in cycles
  logic [31:0]  carrier_q;          // Carrier frequency
  logic [31:0]  hop_q;              // Hop frequency
  logic [31:0]  speriod_q;          // Shift period in cycles
  logic [31:0]  sw_start_q;         // Sweep start frequency
  logic [31:0]  sw_stop_q;          // Sweep stop frequency
  logic [31:0]  sw_time_q;          // Sweep duration in ms
  burst_state_t state_q;            // Burst sequencer state
  logic         ext_prev_q;         // Last sample of trigger input
  logic         imm_pend_q;         // Repeat tick seen during a burst
  logic         opc_arm_q;          // Operation complete armed
  logic         rep_tick;           // Repeat timer tick
  logic         shift_tick;         // Shift timer tick
  logic         last_cycle;         // Final carrier cycle of burst
  logic         trig;               // Selected trigger event
  logic         bus_trg;            // Bus trigger command or message
  logic         gated;              // Gated burst in effect
  logic [31:0]  fmax;               // Frequency ceiling for shape

  //////////////////////////////////////////////////////////////////////
  // Helpers
  //////////////////////////////////////////////////////////////////////
  // Clamp a written value into a legal range
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : clamp

  // Write strobe for one register offset
  function automatic logic wr_at(input logic [5:0] a);
    return i_wr && (i_addr == a);
  endfunction : wr_at

  assign fmax    = slow_q ? `FREQ_SLOW : `FREQ_MAX;
  assign gated   = bsrc_q;
  assign bus_trg = (wr_at(`A_CMD) && i_wdata[`F_TRG]) || i_group_trigger;

  //////////////////////////////////////////////////////////////////////
  // Mode and configuration registers
  //////////////////////////////////////////////////////////////////////
  // Enabling one mode clears the others
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= 3'h0;
    end else if (wr_at(`A_MODE)) begin
      if (i_wdata[`F_BURST_EN]) begin
        mode_q <= 3'h1;
      end else if (i_wdata[`F_KEY_EN]) begin
        mode_q <= 3'h2;
      end else if (i_wdata[`F_SWP_EN]) begin
        mode_q <= 3'h4;
      end else begin
        mode_q <= 3'h0;
      end
    end
  end

  // Sources and shape; apply command forces immediate
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tsrc_q  <= SRC_IMMEDIATE;
      bsrc_q  <= 1'b0;
      ksrc_q  <= 1'b0;
      space_q <= 1'b0;
      slow_q  <= 1'b0;
    end else if (wr_at(`A_CMD) && i_wdata[`F_APPLY]) begin
      tsrc_q  <= SRC_IMMEDIATE;
    end else if (wr_at(`A_CFG)) begin
      // Unused code 3 falls back to immediate
      tsrc_q  <= (i_wdata[`F_TSRC_LO+1 -: 2] == 2'h3) ? SRC_IMMEDIATE
                 : trig_src_t'(i_wdata[`F_TSRC_LO+1 -: 2]);
      bsrc_q  <= i_wdata[`F_BSRC];
      ksrc_q  <= i_wdata[`F_KSRC];
      space_q <= i_wdata[`F_SPACE];
      slow_q  <= i_wdata[`F_SLOW];
    end
  end

  // Burst parameters
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bcount_q  <= `BCOUNT_DEF;
      bperiod_q <= BPER_DEF;
      o_burst_phase <= 32'h0;
    end else begin
      if (wr_at(`A_BCOUNT)) begin
        bcount_q <= 16'(clamp(i_wdata, 32'(`BCOUNT_MIN), 32'(`BCOUNT_MAX)));
      end
      if (wr_at(`A_BPERIOD)) begin
        bperiod_q <= clamp(i_wdata, SPER_MIN, 32'hffffffff);
      end
      if (wr_at(`A_BPHASE)) begin
        o_burst_phase <= i_wdata;
      end
    end
  end

  // Keying frequencies and shift period
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      carrier_q <= `CARRIER_DEF;
      hop_q     <= `HOP_DEF;
      speriod_q <= SPER_DEF;
    end else begin
      if (wr_at(`A_CARRIER)) begin
        carrier_q <= clamp(i_wdata, `FREQ_MIN, fmax);
      end
      if (wr_at(`A_HOP)) begin
        hop_q <= clamp(i_wdata, `FREQ_MIN, fmax);
      end
      if (wr_at(`A_SPERIOD)) begin
        speriod_q <= clamp(i_wdata, SPER_MIN, 32'hffffffff);
      end
    end
  end

  // Sweep setup
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_start_q <= `HOP_DEF;
      sw_stop_q  <= `CARRIER_DEF;
      sw_time_q  <= `SWT_DEF;
    end else begin
      if (wr_at(`A_SW_START)) begin
        sw_start_q <= clamp(i_wdata, `FREQ_MIN, fmax);
      end
      if (wr_at(`A_SW_STOP)) begin
        sw_stop_q <= clamp(i_wdata, `FREQ_MIN, fmax);
      end
      if (wr_at(`A_SW_TIME)) begin
        sw_time_q <= clamp(i_wdata, `SWT_MIN, `SWT_MAX);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Burst sequencer
  //////////////////////////////////////////////////////////////////////
  // Repeat timer runs only for immediate triggering
  rate_timer #(.W(32)) u_rep (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (mode_q[0] && !gated && tsrc_q == SRC_IMMEDIATE),
    .i_period   (bperiod_q),
    .o_tick     (rep_tick)
  );

  // Counts carrier wraps of the running burst
  cycle_counter #(.W(16)) u_cyc (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_start    (state_q != BS_RUN),
    .i_wrap     (i_cycle_wrap && state_q == BS_RUN),
    .i_target   (bcount_q),
    .o_last     (last_cycle)
  );

  // Trigger selection by source
  always_comb begin
    unique case (tsrc_q)
      SRC_IMMEDIATE: trig = rep_tick || imm_pend_q;
      SRC_EXTERNAL:  trig = i_ext_trig && !ext_prev_q;
      SRC_BUS:       trig = bus_trg;
      default:       trig = 1'b0;
    endcase
  end

  // Edge history and late repeat ticks
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_prev_q <= 1'b0;
      imm_pend_q <= 1'b0;
    end else begin
      ext_prev_q <= i_ext_trig;
      if (state_q == BS_RUN && rep_tick) begin
        imm_pend_q <= 1'b1;        // Retrigger once the burst ends
      end else if (state_q == BS_ARMED || tsrc_q != SRC_IMMEDIATE) begin
        imm_pend_q <= 1'b0;
      end
    end
  end

  // Idle, armed, run; triggers during run are dropped, except immediate repeat ticks, which wait in imm_pend_q
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= BS_IDLE;
    end else if (!mode_q[0] || gated) begin
      state_q <= BS_IDLE;
    end else begin
      unique case (state_q)
        BS_IDLE:  state_q <= BS_ARMED;
        BS_ARMED: if (trig) begin
          state_q <= BS_RUN;
        end
        BS_RUN:   if (last_cycle) begin
          state_q <= BS_ARMED;
        end
        default:  state_q <= BS_IDLE;
      endcase
    end
  end

  // Output gate, start and done pulses, busy and wait flags
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_enable  <= 1'b1;
      o_burst_start <= 1'b0;
      o_burst_done  <= 1'b0;
      o_busy        <= 1'b0;
      o_trig_wait   <= 1'b0;
    end else begin
      if (mode_q[0] && gated) begin
        o_out_enable <= i_ext_trig;
      end else if (mode_q[0]) begin
        o_out_enable <= (state_q == BS_RUN && !last_cycle) ||
                        (state_q == BS_ARMED && trig);
      end else begin
        o_out_enable <= 1'b1;
      end
      o_burst_start <= mode_q[0] && !gated && state_q == BS_ARMED && trig;
      o_burst_done  <= state_q == BS_RUN && last_cycle;
      o_busy        <= (state_q == BS_ARMED && trig) ||
                       (state_q == BS_RUN && !last_cycle);
      o_trig_wait   <= mode_q[0] && !gated && tsrc_q == SRC_EXTERNAL &&
                       (state_q == BS_ARMED && !trig ||
                        state_q == BS_RUN && last_cycle);
    end
  end

  // Operation complete flag, set wins over clear
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opc_arm_q     <= 1'b0;
      o_op_complete <= 1'b0;
    end else begin
      if (state_q == BS_RUN && last_cycle && opc_arm_q) begin
        o_op_complete <= 1'b1;
        opc_arm_q     <= 1'b0;
      end else begin
        if (wr_at(`A_CMD) && i_wdata[`F_OPC_CLR]) begin
          o_op_complete <= 1'b0;
        end
        if (wr_at(`A_CMD) && i_wdata[`F_OPC]) begin
          opc_arm_q <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Frequency shift keying
  //////////////////////////////////////////////////////////////////////
  // Shift timer runs only for internal keying
  rate_timer #(.W(32)) u_shift (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (mode_q[1] && !ksrc_q),
    .i_period   (speriod_q),
    .o_tick     (shift_tick)
  );

  // Carrier or hop selection and the frequency presented
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sel_hop <= 1'b0;
      o_freq    <= `CARRIER_DEF;
    end else begin
      if (!mode_q[1]) begin
        o_sel_hop <= 1'b0;
      end else if (ksrc_q) begin
        o_sel_hop <= i_keying_level_input;
      end else if (shift_tick) begin
        o_sel_hop <= !o_sel_hop;
      end
      o_freq <= (mode_q[1] && o_sel_hop) ? hop_q : carrier_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register read port
  //////////////////////////////////////////////////////////////////////
  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0;
    end else if (!i_rd) begin
      o_rdata <= 32'h0;
    end else begin
      unique case (i_addr)
        `A_MODE:     o_rdata <= {29'h0, mode_q};
        `A_CFG:      o_rdata <= {24'h0, slow_q, space_q, ksrc_q, bsrc_q,
                                 2'h0, tsrc_q};
        `A_BCOUNT:   o_rdata <= {16'h0, bcount_q};
        `A_BPERIOD:  o_rdata <= bperiod_q;
        `A_BPHASE:   o_rdata <= o_burst_phase;
        `A_CARRIER:  o_rdata <= carrier_q;
        `A_HOP:      o_rdata <= hop_q;
        `A_SPERIOD:  o_rdata <= speriod_q;
        `A_SW_START: o_rdata <= sw_start_q;
        `A_SW_STOP:  o_rdata <= sw_stop_q;
        `A_SW_TIME:  o_rdata <= sw_time_q;
        `A_STATUS:   o_rdata <= {26'h0, sw_start_q < sw_stop_q,
                                 o_sel_hop, o_busy, o_trig_wait,
                                 state_q == BS_RUN, o_op_complete};
        default:     o_rdata <= 32'h0;
      endcase
    end
  end

  assign o_trigger_source_select = tsrc_q;

  //////////////////////////////////////////////////////////////////////
  // Assertions
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_one_mode;
    wr_at(`A_MODE) && i_wdata[`F_BURST_EN] |=> mode_q == 3'h1;
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("mode not exclusive");

  property p_burst_query;
    i_rd && i_addr == `A_MODE |=> o_rdata[0] == $past(mode_q[0]);
  endproperty
  a_burst_query: assert property (p_burst_query) else $error("bad enable read");

  property p_hold;
    o_burst_done && !gated |-> !o_out_enable;
  endproperty
  a_hold: assert property (p_hold) else $error("output on after burst");

  property p_apply;
    wr_at(`A_CMD) && i_wdata[`F_APPLY] |=> tsrc_q == SRC_IMMEDIATE;
  endproperty
  a_apply: assert property (p_apply) else $error("apply kept source");

  property p_ext_start;
    state_q == BS_ARMED && mode_q[0] && !gated && tsrc_q == SRC_EXTERNAL &&
      i_ext_trig && !ext_prev_q |=> o_burst_start ##0 state_q == BS_RUN;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("edge missed");

  property p_bus;
    state_q == BS_ARMED && mode_q[0] && !gated && tsrc_q == SRC_BUS &&
      bus_trg |=> o_burst_start && o_busy;
  endproperty
  a_bus: assert property (p_bus) else $error("bus trigger missed");

  property p_gate;
    mode_q[0] && gated |=> o_out_enable == $past(i_ext_trig);
  endproperty
  a_gate: assert property (p_gate) else $error("gate not followed");

  property p_no_retrig;
    state_q == BS_RUN && !last_cycle && mode_q[0] && !gated |=> !o_burst_start;
  endproperty
  a_no_retrig: assert property (p_no_retrig) else $error("retriggered");

  property p_key_ext;
    mode_q[1] && ksrc_q |=> o_sel_hop == $past(i_keying_level_input) ##1
      o_freq == ($past(o_sel_hop) ? $past(hop_q) : $past(carrier_q)) || !$past(mode_q[1]);
  endproperty
  a_key_ext: assert property (p_key_ext) else $error("keying wrong");

  property p_opc;
    state_q == BS_RUN && last_cycle && opc_arm_q |=> o_op_complete && o_burst_done;
  endproperty
  a_opc: assert property (p_opc) else $error("completion lost");

  c_burst_done:  cover property (o_burst_done && tsrc_q == SRC_IMMEDIATE);
  c_ext_burst:   cover property (o_burst_start && tsrc_q == SRC_EXTERNAL);
  c_key_hop:     cover property (mode_q[1] && $rose(o_sel_hop));
endmodule : mod_control

// *** hw/modctl_cfg.svh ***
`ifndef MODCTL_CFG_SVH
`define MODCTL_CFG_SVH
// Register byte offsets
`define A_MODE      6'h00
`define A_CFG       6'h04
`define A_BCOUNT    6'h08
`define A_BPERIOD   6'h0c
`define A_BPHASE    6'h10
`define A_CARRIER   6'h14
`define A_HOP       6'h18
`define A_SPERIOD   6'h1c
`define A_SW_START  6'h20
`define A_SW_STOP   6'h24
`define A_SW_TIME   6'h28
`define A_CMD       6'h2c
`define A_STATUS    6'h30
// Mode register bits
`define F_BURST_EN  0
`define F_KEY_EN    1
`define F_SWP_EN    2
// Config register fields
`define F_TSRC_LO   0
`define F_BSRC      4
`define F_KSRC      5
`define F_SPACE     6
`define F_SLOW      7
// Command register bits
`define F_TRG       0
`define F_OPC       1
`define F_APPLY     2
`define F_OPC_CLR   3
// Timing, in Hz and mHz
`define CLK_HZ        64'd125000000
`define BRATE_DEF_MHZ 64'd100000
`define SRATE_DEF_MHZ 64'd10000
`define RATE_MAX_MHZ  64'd50000000
// Limits and reset values, frequencies in 10 mHz units
`define BCOUNT_MIN  16'h0001
`define BCOUNT_MAX  16'hc350
`define BCOUNT_DEF  16'h0001
`define FREQ_MIN    32'h00000001
`define FREQ_MAX    32'h59682f00
`define FREQ_SLOW   32'h00989680
`define CARRIER_DEF 32'h000186a0
`define HOP_DEF     32'h00002710
`define SWT_MIN     32'h00000001
`define SWT_MAX     32'h0007a120
`define SWT_DEF     32'h000003e8
`endif

// *** hw/modctl_pkg.sv ***
package modctl_pkg;
  // Trigger source codes as read back
  typedef enum logic [1:0] {
    SRC_IMMEDIATE = 2'h0,
    SRC_EXTERNAL  = 2'h1,
    SRC_BUS       = 2'h2
  } trig_src_t;
  // Burst sequencer states, Gray along idle, armed, run
  typedef enum logic [1:0] {
    BS_IDLE  = 2'b00,
    BS_ARMED = 2'b01,
    BS_RUN   = 2'b11
  } burst_state_t;
endpackage : modctl_pkg

// *** hw/rate_timer.sv ***
`timescale 1ns/1ps
// Free running period timer, one tick per period while running
module rate_timer #(
  parameter int W = 32
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_period,
  output logic              o_tick
);
  logic [W-1:0] cnt_q;  // Cycles elapsed in this period

  // Count up, wrap at period, restart when stopped
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q + W'(1) >= i_period) begin
      cnt_q  <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + W'(1);
      o_tick <= 1'b0;
    end
  end
endmodule : rate_timer

// *** hw/cycle_counter.sv ***
`timescale 1ns/1ps
// Counts carrier cycle wraps and flags the last one of a burst
module cycle_counter #(
  parameter int W = 16
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_start,
  input  wire logic         i_wrap,
  input  wire logic [W-1:0] i_target,
  output logic              o_last
);
  logic [W-1:0] cnt_q;  // Cycles finished so far

  // Clear on start, step on each wrap
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (i_start) begin
      cnt_q <= '0;
    end else if (i_wrap) begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  // Combinational: this wrap ends the burst
  assign o_last = i_wrap && (cnt_q + W'(1) >= i_target);
endmodule : cycle_counter

// *** dv/wrap_model.sv ***
`timescale 1ns/1ps
// Datapath stand-in: a one-cycle wrap every fourth cycle while on
module wrap_model (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_run,
  output logic      o_wrap
);
  logic [1:0] ph_q; // Phase inside one carrier cycle
  // Phase restarts whenever the output stops
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_q   <= 2'h0;
      o_wrap <= 1'b0;
    end else begin
      ph_q   <= i_run ? ph_q + 2'h1 : 2'h0;
      o_wrap <= i_run && ph_q == 2'h3;
    end
  end
endmodule : wrap_model

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`include "modctl_cfg.svh"
module testbench;
  import modctl_pkg::*;
  typedef struct {logic [5:0] wa; logic [31:0] wd; logic [5:0] ra; logic [31:0] m; logic [31:0] e;} row_t;
  logic        i_core_clk = 1'b0; // Core clock
  logic        i_rst_n = 1'b0;    // Reset, low active
  logic [5:0]  i_addr = 6'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 0, i_rd = 0, i_ext_trig = 0, i_group_trigger = 0, i_keying_level_input = 0;
  logic        i_cycle_wrap, o_out_enable, o_burst_start, o_burst_done, o_op_complete, o_busy, o_trig_wait;
  logic        o_sel_hop, v;
  logic [31:0] o_rdata, o_burst_phase, o_freq, got;
  trig_src_t   o_trigger_source_select;
  int          bad_count = 0, compares = 0, n_start = 0, n_wrap = 0, s0, w0, n;
  // Write, then read back masked
  row_t rows [18] = '{
    '{6'h3c, 0, `A_BCOUNT, '1, 1}, '{6'h3c, 0, `A_HOP, '1, `HOP_DEF}, '{6'h3c, 0, `A_CARRIER, '1, `CARRIER_DEF},
    '{6'h3c, 5, 6'h3c, '1, 0}, '{6'h3c, 0, `A_CFG, 32'h20, 0}, '{`A_MODE, 1, `A_MODE, 7, 1},
    '{`A_MODE, 3, `A_MODE, 7, 1}, '{`A_MODE, 2, `A_MODE, 7, 2}, '{`A_MODE, 4, `A_MODE, 7, 4},
    '{`A_MODE, 0, `A_MODE, 7, 0},
    '{`A_BCOUNT, 0, `A_BCOUNT, '1, 1}, '{`A_BCOUNT, 32'hc351, `A_BCOUNT, '1, 32'hc350},
    '{`A_HOP, 0, `A_HOP, '1, 1}, '{`A_SW_START, 5, `A_SW_TIME, '1, `SWT_DEF},
    '{`A_SW_STOP, 9, `A_STATUS, 32'h20, 32'h20}, '{`A_SW_START, 32'hff, `A_STATUS, 32'h20, 0},
    '{`A_CFG, 32'h40, `A_CFG, 32'h40, 32'h40}, '{`A_CFG, 3, `A_CFG, 3, 0}};
  mod_control #(.BPER_DEF(50), .SPER_DEF(50)) mod_control_inst (.i_core_clk, .i_rst_n, .i_addr, .i_wdata,
    .i_wr, .i_rd, .i_ext_trig, .i_group_trigger, .i_keying_level_input, .i_cycle_wrap, .o_rdata, .o_out_enable,
    .o_burst_start, .o_burst_phase, .o_burst_done, .o_op_complete, .o_busy, .o_trig_wait, .o_sel_hop, .o_freq,
    .o_trigger_source_select);
  wrap_model wrap_model_inst (.i_core_clk, .i_rst_n, .i_run(o_out_enable), .o_wrap(i_cycle_wrap));
  always #4 i_core_clk = ~i_core_clk;
  // Count burst starts and carrier cycles sent
  always @(posedge i_core_clk) begin
    n_start += o_burst_start;
    n_wrap  += i_cycle_wrap & o_out_enable;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 got = o_rdata;
  endtask : rd
  task automatic wait_done();
    for (n = 0; n < 300 && o_burst_done !== 1'b1; n++) tick(1);
    chk(o_burst_done, 1'b1);
  endtask : wait_done
  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // Hang guard
  initial begin
    #100us;
    bad_count++;
    print_verdict();
  end
  initial begin
    tick(5);
    chk(32'(o_trigger_source_select), SRC_IMMEDIATE);
    chk(o_freq, `CARRIER_DEF);
    @(posedge i_core_clk) i_rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra);
      chk(got & rows[i].m, rows[i].e);
    end
    $display("table done");
    // External edge, second edge inside the burst
    wr(`A_BCOUNT, 2);
    wr(`A_CFG, 1);
    wr(`A_CMD, 2);
    wr(`A_MODE, 1);
    tick(3);
    chk(o_trig_wait, 1);
    s0 = n_start;
    w0 = n_wrap;
    @(posedge i_core_clk) i_ext_trig <= 1'b1;
    tick(2);
    i_ext_trig <= 1'b0;
    tick(2);
    i_ext_trig <= 1'b1;
    tick(1);
    i_ext_trig <= 1'b0;
    wait_done();
    tick(1);
    chk(o_out_enable, 0);
    chk(o_op_complete, 1);
    chk(n_start - s0, 1);
    chk(n_wrap - w0, 2);
    $display("external done");
    // Register and message bus triggers
    wr(`A_CFG, 2);
    wr(`A_BPHASE, 32'h2d);
    tick(1);
    chk(32'(o_trigger_source_select), SRC_BUS);
    s0 = n_start;
    w0 = n_wrap;
    wr(`A_CMD, 1);
    tick(2);
    chk(o_busy, 1);
    wait_done();
    @(posedge i_core_clk) i_group_trigger <= 1'b1;
    @(posedge i_core_clk) i_group_trigger <= 1'b0;
    wait_done();
    tick(100);
    chk(n_start - s0, 2);
    chk(n_wrap - w0, 4);
    chk(o_burst_phase, 32'h2d);
    wr(`A_CMD, 4);
    tick(1);
    chk(32'(o_trigger_source_select), SRC_IMMEDIATE);
    s0 = n_start;
    tick(300);
    chk(32'(n_start - s0 >= 5), 1);
    $display("bus and immediate done");
    // Gate level rules the output
    wr(`A_CFG, 32'h11);
    tick(1);
    s0 = n_start;
    i_ext_trig <= 1'b1;
    tick(3);
    chk(o_out_enable, 1);
    i_ext_trig <= 1'b0;
    tick(103);
    chk(o_out_enable, 0);
    chk(n_start - s0, 0);
    $display("gated done");
    // Keying level held over 1 us between changes
    wr(`A_MODE, 2);
    wr(`A_CFG, 32'h20);
    i_keying_level_input <= 1'b1;
    tick(130);
    chk(o_sel_hop, 1);
    chk(o_freq, 1);
    i_keying_level_input <= 1'b0;
    tick(130);
    chk(o_sel_hop, 0);
    chk(o_freq, `CARRIER_DEF);
    wr(`A_CFG, 0);
    w0 = 0;
    v = o_sel_hop;
    for (n = 0; n < 200; n++) begin
      tick(1);
      w0 += (o_sel_hop !== v);
      v = o_sel_hop;
    end
    chk(32'(w0 >= 3 && w0 <= 5), 1);
    $display("keying done");
    print_verdict();
  end
endmodule : testbench
